// ===== vps_guard.sv
// Purpose: Reset address, vector base and guarded vector select
// Assumes: Fuses are static after reset; in_boot_section from the core
// Notes:   Dispatch block is an output; the core's I flag is untouched
`timescale 1ns/10ps

// Operation
// - Programmed boot fuse starts at boot address
// - Relocated vectors are offset by boot start
// - Reset and vector start per fuse, select
// - Entries two words apart, last 0x0032
// - 2K boot: reset 0x1C00, vectors 0x1C02
// - Control bit 1 selects vector placement
// - Boot start derived from boot size fuses
// - Block dispatch from enable until after instruction
// - Unused enable blocks exactly five cycles
// - Blocking never alters global interrupt flag
// - Enable bit 0 clears after four cycles
// - Boot vectors, app lock: block in app
// - App vectors, boot lock: block in boot
// - Every reset cause shares reset vector
module vps_guard
  import vps_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                nrst,
  input  wire vps_pkg::vps_fuse_type fuses,
  input  wire vps_pkg::vps_bus_type  bus,
  input  wire logic                in_boot_section,
  input  wire logic                instr_done,
  input  wire logic [4:0]          vector_index,
  output logic [7:0]               rdata,
  output logic [13:0]              reset_address,
  output logic [13:0]              vector_base,
  output logic [13:0]              vector_address,
  output logic                     vector_table_select,
  output logic                     dispatch_block
);
  import vps_pkg::*;

  // ---------------------------------------------------------------
  // Boot section start and address outputs
  // ---------------------------------------------------------------
  logic [13:0] boot_start;
  logic [13:0] boot_start_d;
  logic [13:0] boot_start_q;
  logic [13:0] reset_addr_d;
  logic [13:0] base_d;
  logic [13:0] vec_ofs;
  logic [13:0] vec_addr_d;
  logic        vsel_q;

  assign boot_start_d =
    (fuses.boot_size_fuses == BOOT_SIZE_FUSES_2K)  ? BOOT_2K_START :
    (fuses.boot_size_fuses == BOOT_SIZE_FUSES_1K)  ? BOOT_1K_START :
    (fuses.boot_size_fuses == BOOT_SIZE_FUSES_512) ? BOOT_512_START :
                                            BOOT_256_START;
  assign boot_start = boot_start_q;

  // Fuse 1 means unprogrammed; every reset cause lands here
  assign reset_addr_d = fuses.boot_reset_select_fuse ?
                        RESET_WORD : boot_start;
  assign base_d = vsel_q ? boot_start : RESET_WORD;

  // Index 0 is reset entry; clamp to last table entry
  assign vec_ofs = (vector_index > 5'd25) ? VEC_LAST_OFS :
                   {8'h00, vector_index, 1'b0};
  assign vec_addr_d = base_d + vec_ofs;

  // Fuses are sampled each clock; they are static, so no sync chain
  logic [13:0] reset_addr_q;
  logic [13:0] base_q;
  logic [13:0] vec_addr_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      boot_start_q <= BOOT_2K_START;
      reset_addr_q <= RESET_WORD;
      base_q       <= RESET_WORD;
      vec_addr_q   <= RESET_WORD;
    end else begin
      boot_start_q <= boot_start_d;
      reset_addr_q <= reset_addr_d;
      base_q       <= base_d + VEC_STEP;
      vec_addr_q   <= vec_addr_d;
    end
  end

  assign reset_address  = reset_addr_q;
  assign vector_base    = base_q;
  assign vector_address = vec_addr_q;

  // ---------------------------------------------------------------
  // Guarded change sequence
  // ---------------------------------------------------------------
  logic          vsel_d;
  logic          chg_q;
  logic          chg_d;
  logic [2:0]    cnt_q;
  logic [2:0]    cnt_d;
  logic          tail_q;
  logic          tail_d;
  vps_state_type st_q;
  vps_state_type st_d;

  wire ctrl_wr   = bus.wr && (bus.addr == CTRL_OFFSET);
  wire set_chg   = ctrl_wr && bus.wdata[CHG_EN_BIT];
  // Select write counts only with enable open and enable written 0
  wire sel_wr    = ctrl_wr && chg_q && !bus.wdata[CHG_EN_BIT];
  wire expire    = chg_q && (cnt_q == CHG_WINDOW_CYC - 3'h1);

  always_comb begin
    st_d   = st_q;
    chg_d  = chg_q;
    cnt_d  = cnt_q;
    vsel_d = vsel_q;
    tail_d = tail_q && !instr_done;
    case (st_q)
      ST_IDLE: begin
        if (set_chg) begin
          st_d  = ST_OPEN;
          chg_d = 1'b1;
          cnt_d = 3'h0;
        end
      end
      ST_OPEN: begin
        cnt_d = cnt_q + 3'h1;
        if (sel_wr) begin
          vsel_d = bus.wdata[VSEL_BIT];
          chg_d  = 1'b0;
          tail_d = 1'b1;
          st_d   = ST_IDLE;
        end else if (set_chg) begin
          cnt_d = 3'h0;
        end else if (expire) begin
          chg_d = 1'b0;
          st_d  = ST_IDLE;
        end
      end
      default: begin
        st_d  = ST_IDLE;
        chg_d = 1'b0;
      end
    endcase
    // Writes outside the open window leave select alone
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_q   <= ST_IDLE;
      vsel_q <= VSEL_RESET;
      chg_q  <= CHG_EN_RESET;
      cnt_q  <= 3'h0;
      tail_q <= 1'b0;
    end else begin
      st_q   <= st_d;
      vsel_q <= vsel_d;
      chg_q  <= chg_d;
      cnt_q  <= cnt_d;
      tail_q <= tail_d;
    end
  end

  assign vector_table_select = vsel_q;

  // ---------------------------------------------------------------
  // Dispatch block, separate from the core's own enable flag
  // ---------------------------------------------------------------
  wire lock_block =
    (vsel_q && fuses.app_section_boot_lock && !in_boot_section) ||
    (!vsel_q && fuses.boot_section_boot_lock && in_boot_section);

  // Combinational so blocking starts the same cycle enable is set
  assign dispatch_block = set_chg || chg_q || tail_q ||
                          lock_block;

  // ---------------------------------------------------------------
  // Register read port
  // ---------------------------------------------------------------
  wire [7:0] ctrl_rd = {6'h00, vsel_q, chg_q};
  wire [7:0] stat_rd = {7'h00, dispatch_block};
  wire [7:0] rd_d    = !bus.rd                   ? 8'h00 :
                       (bus.addr == CTRL_OFFSET) ? ctrl_rd :
                       (bus.addr == STAT_OFFSET) ? stat_rd : 8'h00;
  logic [7:0] rdata_q;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rd_d;
    end
  end

  assign rdata = rdata_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_enable;
    set_chg && !chg_q;
  endsequence

  sequence s_no_select;
    !ctrl_wr [*4];
  endsequence

  property p_expire;
    @(posedge core_clk) disable iff (!nrst)
      s_enable ##1 s_no_select |=> !chg_q;
  endproperty
  a_expire: assert property (p_expire)
    else $error("change enable did not expire after four cycles");

  property p_held;
    @(posedge core_clk) disable iff (!nrst)
      s_enable ##1 s_no_select |-> chg_q;
  endproperty
  a_held: assert property (p_held)
    else $error("change enable dropped early");

  property p_block_now;
    @(posedge core_clk) disable iff (!nrst)
      set_chg |-> dispatch_block ##1 dispatch_block;
  endproperty
  a_block_now: assert property (p_block_now)
    else $error("dispatch not blocked when enable set");

  property p_ignore;
    @(posedge core_clk) disable iff (!nrst)
      (ctrl_wr && !chg_q) |=> (vsel_q == $past(vsel_q));
  endproperty
  a_ignore: assert property (p_ignore)
    else $error("select changed without enable");

  property p_sel_clear;
    @(posedge core_clk) disable iff (!nrst)
      sel_wr |=> !chg_q && tail_q;
  endproperty
  a_sel_clear: assert property (p_sel_clear)
    else $error("select write did not close window");

  property p_reset_addr;
    @(posedge core_clk) disable iff (!nrst)
      $past(nrst) |->
        (reset_address == ($past(fuses.boot_reset_select_fuse)
           ? RESET_WORD : $past(boot_start)));
  endproperty
  a_reset_addr: assert property (p_reset_addr)
    else $error("reset address wrong");

  property p_base;
    @(posedge core_clk) disable iff (!nrst)
      $past(nrst) |->
        (vector_base == ($past(vsel_q) ? $past(boot_start) + VEC_STEP
                                       : VEC_STEP));
  endproperty
  a_base: assert property (p_base)
    else $error("vector base wrong");

  property p_lock_app;
    @(posedge core_clk) disable iff (!nrst)
      (vsel_q && fuses.app_section_boot_lock && !in_boot_section)
        |-> dispatch_block;
  endproperty
  a_lock_app: assert property (p_lock_app)
    else $error("app section not blocked");

  property p_lock_boot;
    @(posedge core_clk) disable iff (!nrst)
      (!vsel_q && fuses.boot_section_boot_lock && in_boot_section)
        |-> dispatch_block;
  endproperty
  a_lock_boot: assert property (p_lock_boot)
    else $error("boot section not blocked");

  // ---------------------------------------------------------------
  // Read port, dispatch tail, change enable and table checks
  // ---------------------------------------------------------------
  property p_rd_idle;
    @(posedge core_clk) disable iff (!nrst)
      !bus.rd |=> (rdata == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not zero outside a read");

  property p_rd_ctrl;
    @(posedge core_clk) disable iff (!nrst)
      (bus.rd && (bus.addr == CTRL_OFFSET))
        |=> (rdata == {6'h00, $past(vsel_q), $past(chg_q)});
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("control read data wrong");

  property p_rd_stat;
    @(posedge core_clk) disable iff (!nrst)
      (bus.rd && (bus.addr == STAT_OFFSET))
        |=> (rdata == {7'h00, $past(dispatch_block)});
  endproperty
  a_rd_stat: assert property (p_rd_stat)
    else $error("status read data wrong");

  property p_rd_unmapped;
    @(posedge core_clk) disable iff (!nrst)
      (bus.rd && (bus.addr != CTRL_OFFSET) && (bus.addr != STAT_OFFSET))
        |=> (rdata == 8'h00);
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped)
    else $error("unmapped read data not zero");

  property p_tail_hold;
    @(posedge core_clk) disable iff (!nrst)
      (tail_q && !instr_done) |=> dispatch_block;
  endproperty
  a_tail_hold: assert property (p_tail_hold)
    else $error("dispatch block ended before instruction done");

  property p_tail_end;
    @(posedge core_clk) disable iff (!nrst)
      (tail_q && instr_done && !sel_wr) |=> !tail_q;
  endproperty
  a_tail_end: assert property (p_tail_end)
    else $error("dispatch block outlived the instruction");

  property p_no_self_set;
    @(posedge core_clk) disable iff (!nrst)
      (!chg_q && !set_chg) |=> !chg_q;
  endproperty
  a_no_self_set: assert property (p_no_self_set)
    else $error("change enable rose without a write");

  property p_vec_step;
    @(posedge core_clk) disable iff (!nrst)
      ($past(nrst) && ($past(vector_index) <= 5'd25)) |->
        (vector_address == ($past(vsel_q) ? $past(boot_start) : RESET_WORD)
                           + {8'h00, $past(vector_index), 1'b0});
  endproperty
  a_vec_step: assert property (p_vec_step)
    else $error("vector address wrong");

  property p_vec_last;
    @(posedge core_clk) disable iff (!nrst)
      ($past(nrst) && ($past(vector_index) > 5'd25)) |->
        (vector_address == ($past(vsel_q) ? $past(boot_start) : RESET_WORD)
                           + VEC_LAST_OFS);
  endproperty
  a_vec_last: assert property (p_vec_last)
    else $error("clamped vector address wrong");

endmodule : vps_guard

// ===== vps_pkg.sv
// Purpose: Constants and types for vector placement and select guard
// Assumes: Word addressed program memory, 14-bit word addresses
// Notes:   Boot size encodings map to boot section start words
package vps_pkg;

  localparam int                  ADDR_W        = 14;
  localparam int                  REG_ADDR_W    = 4;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [3:0]          CTRL_OFFSET   = 4'h0;
  localparam logic [3:0]          STAT_OFFSET   = 4'h1;
  localparam int                  CHG_EN_BIT    = 0;
  localparam int                  VSEL_BIT      = 1;
  localparam logic                VSEL_RESET    = 1'b0;
  localparam logic                CHG_EN_RESET  = 1'b0;
  // ---------------------------------------------------------------
  // Addresses
  // ---------------------------------------------------------------
  localparam logic [13:0]         RESET_WORD    = 14'h0000;
  localparam logic [13:0]         VEC_STEP      = 14'h0002;
  localparam logic [13:0]         VEC_LAST_OFS  = 14'h0032;
  localparam logic [13:0]         BOOT_2K_START = 14'h1C00;
  localparam logic [13:0]         BOOT_1K_START = 14'h1E00;
  localparam logic [13:0]         BOOT_512_START = 14'h1F00;
  localparam logic [13:0]         BOOT_256_START = 14'h1F80;
  localparam logic [1:0]          BOOT_SIZE_FUSES_2K     = 2'h0;
  localparam logic [1:0]          BOOT_SIZE_FUSES_1K     = 2'h1;
  localparam logic [1:0]          BOOT_SIZE_FUSES_512    = 2'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam logic [2:0]          CHG_WINDOW_CYC = 3'h4;

  typedef struct packed {
    logic                         boot_reset_select_fuse;
    logic [1:0]                   boot_size_fuses;
    logic                         app_section_boot_lock;
    logic                         boot_section_boot_lock;
  } vps_fuse_type;

  typedef struct packed {
    logic [3:0]                   addr;
    logic [7:0]                   wdata;
    logic                         wr;
    logic                         rd;
  } vps_bus_type;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OPEN = 2'b10
  } vps_state_type;

endpackage : vps_pkg

// ===== vps_core_model.sv
// Purpose: Core-side model that drives the register port
// Assumes: Single master; strobes are one cycle long
// Notes:   Every change is a non-blocking update just after a rising edge
`timescale 1ns/10ps

module vps_core_model
  import vps_pkg::*;
(
  input  wire logic            core_clk,
  input  wire logic [7:0]      rdata,
  output vps_pkg::vps_bus_type bus
);
  import vps_pkg::*;

  initial bus = '0;

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    bus.rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
  endtask : rd

  // Second write lands two cycles after the enable, inside the window
  task automatic move(input logic v);
    wr(CTRL_OFFSET, 8'h01);
    wr(CTRL_OFFSET, {6'h00, v, 1'b0});
  endtask : move
endmodule : vps_core_model

// ===== vector_placement_and_select_guard_bench.sv
// Purpose: Self-checking bench for the vector placement guard
// Assumes: Locks and fuses are driven as static levels between steps
// Notes:   Expected values come from a small model kept in the bench
`timescale 1ns/10ps

module vector_placement_and_select_guard_bench;
  import vps_pkg::*;
  logic         core_clk, nrst, in_boot, instr_done, vsel, blk, m_sel;
  vps_fuse_type fuses;
  vps_bus_type  bus;
  logic [4:0]   vidx;
  logic [7:0]   rdata, rv;
  logic [13:0]  rst_a, vbase, vaddr;
  int           fail_count, n_compared, cyc, n;

  vps_guard dut_u (.core_clk(core_clk), .nrst(nrst), .fuses(fuses),
    .bus(bus), .in_boot_section(in_boot), .instr_done(instr_done),
    .vector_index(vidx), .rdata(rdata), .reset_address(rst_a),
    .vector_base(vbase), .vector_address(vaddr),
    .vector_table_select(vsel), .dispatch_block(blk));
  vps_core_model core_u (.core_clk(core_clk), .rdata(rdata), .bus(bus));

  task automatic chk(input logic [13:0] s, input logic [13:0] e);
    n_compared++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up

  function automatic logic [13:0] bstart(input logic [1:0] s);
    return s == BOOT_SIZE_FUSES_2K ? BOOT_2K_START : s == BOOT_SIZE_FUSES_1K ? BOOT_1K_START
         : s == BOOT_SIZE_FUSES_512 ? BOOT_512_START : BOOT_256_START;
  endfunction : bstart

  task automatic check_addr();
    logic [13:0] tb;
    int          k;
    k  = vidx > 25 ? 25 : vidx;
    tb = m_sel ? bstart(fuses.boot_size_fuses) : RESET_WORD;
    chk(rst_a, fuses.boot_reset_select_fuse ? RESET_WORD
               : bstart(fuses.boot_size_fuses));
    chk(vbase, tb + VEC_STEP);
    chk(vaddr, tb + 14'(2 * k));
  endtask : check_addr

  // Block clears only after the instruction that follows the select write
  task automatic pulse_done();
    @(posedge core_clk);
    instr_done <= 1'b1;
    @(posedge core_clk);
    instr_done <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : pulse_done

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Whole run is well under a thousand cycles
  initial begin
    cyc = 0;
    forever begin
      @(posedge core_clk);
      cyc++;
      if (cyc == 4000) begin
        fail_count++;
        wrap_up();
      end
    end
  end

  initial begin
    nrst = 1'b0; fuses = '0; in_boot = 1'b0; instr_done = 1'b0;
    vidx = '0; m_sel = 1'b0; fail_count = 0; n_compared = 0;
    void'($urandom(61282));
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    core_u.rd(CTRL_OFFSET, rv);
    chk(14'(rv), 14'h0000);
    $display("test reset done");
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        core_u.move(1'b1);
        m_sel = 1'b1;
        pulse_done();
      end
      for (int i = 0; i < 8; i++) begin
        @(posedge core_clk);
        fuses.boot_reset_select_fuse <= i[0];
        fuses.boot_size_fuses <= i[2:1];
        fuses.app_section_boot_lock <= i[0];
        fuses.boot_section_boot_lock <= i[1];
        in_boot <= i[2];
        vidx <= i > 5 ? 5'(19 + i) : 5'($urandom_range(31));
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
        check_addr();
        chk(14'(vsel), 14'(m_sel));
        chk(14'(blk), 14'((m_sel & i[0] & !i[2])
                        | (!m_sel & i[1] & i[2])));
      end
      @(posedge core_clk);
      fuses <= '0;
      in_boot <= 1'b0;
    end
    $display("test placement and locks done");
    core_u.wr(CTRL_OFFSET, 8'h01);
    n = 0;
    @(negedge core_clk);
    repeat (8) begin
      if (blk === 1'b1) n++;
      @(negedge core_clk);
    end
    chk(14'(n), 14'd4);
    core_u.rd(CTRL_OFFSET, rv);
    chk(14'(rv), 14'h0002);
    core_u.wr(CTRL_OFFSET, 8'h00);
    core_u.rd(CTRL_OFFSET, rv);
    chk(14'(rv), 14'h0002);
    $display("test open window done");
    core_u.move(1'b0);
    m_sel = 1'b0;
    core_u.rd(STAT_OFFSET, rv);
    chk(14'(rv), 14'h0001);
    n = 0;
    repeat (6) begin
      @(negedge core_clk);
      if (blk === 1'b1) n++;
    end
    chk(14'(n), 14'd6);
    chk(14'(vsel), 14'h0000);
    pulse_done();
    chk(14'(blk), 14'h0000);
    core_u.rd(4'h7, rv);
    chk(14'(rv), 14'h0000);
    $display("test select move done");
    core_u.move(1'b1);
    pulse_done();
    @(posedge core_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(14'(vsel), 14'h0000);
    check_addr();
    $display("test second reset done");
    wrap_up();
  end
endmodule : vector_placement_and_select_guard_bench
